//--- pkg/mfc_pkg.sv
// Function
// R1: underflow with recovery disable clear turns transmitter off, clears transmitter-on flag
// R2: recovery disable set: underflow skips to next frame start and restarts transmission
// R3: recovery disable bit always read/write, cleared by reset, kept on stop
// R4: look-ahead raises receive interrupt after first buffer descriptor write-back too
// R5: look-ahead: packets start only in buffers whose descriptor has start flag
// R6: after last descriptor, scan for next start entry, clearing ownership of skipped owned entries
// R7: host-owned entry without start flag is left alone, scan moves on
// R8: start entry not owned: stop scan and poll that entry periodically
// R9: owned start entry: stop scan, keep descriptor, wait for next frame
// R10: look-ahead enable always read/write, reset to zero, kept on stop
// R11: bit 4 disables two-part deferral; cleared by reset, kept on stop
// R12: bit 3 selects modified back-off; cleared by reset; bits 2-0 reserved
// R13: test mode set only by first write after reset; zero locks it off
// R14: bit 14 set disables burst transaction counter; cleared by reset
// R15: timer enable allows mixed accesses per mastership until timer expires or idle
// R16: timer mode releases bus after about 1 us with no request
// R17: timer clear: one access type per mastership, ascending buffer addresses
// R18: bit 12 stops automatic transmit polling; demand bit triggers polls; none while off (code acts on demand only while bit 12 is set)
// R19: auto-pad pads short frames to 64 bytes with checksum appended
// R20: auto-strip removes pad and checksum from received frames
// R21: overflow flag set on counter overflow, write-one clears, reset/stop clear
// R22: overflow mask set keeps flag from summary interrupt
// R23: overflow mask set by reset, kept on stop
package mfc_pkg;
  localparam logic [3:0] ADDR_FEATURE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_TEST_A = 4'hc;
  localparam int BIT_TEST = 15;
  localparam int BIT_BURST_DIS = 14;
  localparam int BIT_TIMER = 13;
  localparam int BIT_POLL_DIS = 12;
  localparam int BIT_APAD = 11;
  localparam int BIT_ASTRP = 10;
  localparam int BIT_MISSED_FRAME_OVERFLOW_FLAG = 9;
  localparam int BIT_MISSED_FRAME_OVERFLOW_MASK = 8;
  localparam int BIT_TRANSMIT_UNDERFLOW_ERROR_DIS = 6;
  localparam int BIT_LAPP = 5;
  localparam int BIT_DEFER_DIS = 4;
  localparam int BIT_MODIFIED_BACKOFF_ENABLE = 3;
  // status bits
  localparam int ST_TRANSMITTER_ON_FLAG = 0;
  localparam int ST_SUMMARY = 1;
  localparam int ST_RECEIVE_INTERRUPT_FLAG = 2;
  localparam int ST_BUS_HELD = 3;
  localparam int ST_SCAN_POLL = 4;
  localparam int ST_SCAN_WAIT = 5;
  localparam int ST_TEST_ARMED = 6;
  // command bits
  localparam int CMD_STOP = 0;
  localparam int CMD_SOFT_RESET = 1;
  localparam int CMD_TX_DEMAND = 2;
  localparam int CMD_TX_START = 3;
  localparam logic [15:0] FEATURE_RESET = 16'h0100;
  localparam int PAD_MIN_BYTES = 64;
  localparam int CLK_MHZ = 40;
  localparam int HOLD_NS = 1000;
  localparam int HOLD_CYCLES = (HOLD_NS * CLK_MHZ) / 1000;
  localparam int POLL_CYCLES = 64;
  typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN, SCAN_POLL, SCAN_WAIT} mfc_scan_type;
endpackage : mfc_pkg

//--- logic/mfc_feature_ctrl.sv
// The address map and the Wishbone register port were decided locally.
module mfc_feature_ctrl #(
  parameter int HOLD_CYCLES = mfc_pkg::HOLD_CYCLES,
  parameter int POLL_CYCLES = mfc_pkg::POLL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // reset-register read from the register port outside this bank
  input wire logic reset_reg_read_i,
  // transmit side events
  input wire logic transmit_underflow_error_i,
  input wire logic tx_frame_start_found_i,
  output logic transmitter_on_flag_o,
  output logic tx_ring_skip_o,
  output logic tx_poll_o,
  output logic two_part_deferral_disable_o,
  output logic modified_backoff_enable_o,
  output logic auto_pad_transmit_o,
  output logic auto_strip_receive_o,
  output logic burst_counter_disable_o,
  output logic test_mode_enable_o,
  // receive descriptor scanning
  input wire logic rx_first_desc_done_i,
  input wire logic rx_last_desc_done_i,
  input wire logic desc_valid_i,
  input wire logic desc_own_i,
  input wire logic desc_start_i,
  input wire logic rx_frame_arrive_i,
  output logic desc_fetch_o,
  output logic desc_clear_own_o,
  output logic desc_advance_o,
  output logic rx_start_allowed_o,
  output logic receive_interrupt_flag_o,
  // bus mastership
  input wire logic bus_req_i,
  input wire logic bus_req_type_change_i,
  output logic bus_hold_o,
  // missed frame counter overflow
  input wire logic missed_frame_counter_ovf_i,
  output logic interrupt_summary_flag_o
);

  initial begin
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) $error("HOLD_CYCLES out of range");
    if (POLL_CYCLES < 1 || POLL_CYCLES > 65535) $error("POLL_CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0] feat;
    logic test_armed;
    logic transmitter_on_flag;
    logic skip;
    logic poll;
    logic receive_interrupt_flag;
    logic summary;
    mfc_pkg::mfc_scan_type scan;
    logic fetch;
    logic clr_own;
    logic adv;
    logic rx_ok;
    logic [15:0] poll_cnt;
    logic hold;
    logic [15:0] hold_cnt;
    logic ack;
    logic [31:0] rdata;
  } mfc_state_type;

  mfc_state_type st;
  mfc_state_type next_st;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  logic req;
  logic wr;
  logic rd;
  logic stop;
  logic [15:0] wval;
  assign req = cyc_i && stb_i && !st.ack;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  assign stop = wr && adr_i == mfc_pkg::ADDR_CMD && sel_i[0] && dat_i[mfc_pkg::CMD_STOP];
  assign wval = merge16(st.feat, dat_i, sel_i);

  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.fetch = 1'b0;
    next_st.clr_own = 1'b0;
    next_st.adv = 1'b0;
    next_st.skip = 1'b0;
    next_st.poll = 1'b0;
    next_st.receive_interrupt_flag = 1'b0;
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (wr && adr_i == mfc_pkg::ADDR_FEATURE) begin
      next_st.feat[15:10] = wval[15:10];
      next_st.feat[8] = wval[8];
      next_st.feat[6:3] = wval[6:3]; // R10
      next_st.feat[2:0] = 3'h0; // R12
      // a one keeps test mode once set; only the first write after reset can raise it
      if (wval[mfc_pkg::BIT_TEST] && (st.test_armed || st.feat[mfc_pkg::BIT_TEST])) begin
        next_st.feat[mfc_pkg::BIT_TEST] = 1'b1; // R13
      end else begin
        next_st.feat[mfc_pkg::BIT_TEST] = 1'b0; // R13
      end
      if (sel_i[1]) begin
        next_st.test_armed = 1'b0; // R13
      end
      if (sel_i[1] && wval[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_FLAG]) begin
        next_st.feat[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_FLAG] = 1'b0; // R21
      end
    end
    if (stop) begin
      next_st.feat[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_FLAG] = 1'b0; // R21
      next_st.transmitter_on_flag = 1'b0;
    end
    if (wr && adr_i == mfc_pkg::ADDR_CMD && sel_i[0] && dat_i[mfc_pkg::CMD_TX_START] && !stop) begin
      next_st.transmitter_on_flag = 1'b1;
    end
    if (missed_frame_counter_ovf_i) begin
      next_st.feat[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_FLAG] = 1'b1; // R21
    end
    next_st.summary = next_st.feat[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_FLAG] && !next_st.feat[mfc_pkg::BIT_MISSED_FRAME_OVERFLOW_MASK]; // R22
    // ------------------------------------------------------------
    // transmit underflow and polling
    // ------------------------------------------------------------
    if (transmit_underflow_error_i && st.transmitter_on_flag) begin
      if (st.feat[mfc_pkg::BIT_TRANSMIT_UNDERFLOW_ERROR_DIS]) begin
        next_st.skip = 1'b1; // R2
      end else begin
        next_st.transmitter_on_flag = 1'b0; // R1
      end
    end
    if (st.transmitter_on_flag && !st.feat[mfc_pkg::BIT_POLL_DIS]) begin
      next_st.poll = st.poll_cnt == 16'h0000; // R18
    end else if (st.transmitter_on_flag && wr && adr_i == mfc_pkg::ADDR_CMD && sel_i[0] && dat_i[mfc_pkg::CMD_TX_DEMAND]) begin
      next_st.poll = 1'b1; // R18
    end
    // ------------------------------------------------------------
    // receive look-ahead scan
    // ------------------------------------------------------------
    if (rx_last_desc_done_i || (rx_first_desc_done_i && st.feat[mfc_pkg::BIT_LAPP])) begin
      next_st.receive_interrupt_flag = 1'b1; // R4
    end
    if (st.poll_cnt == 16'h0000) begin
      next_st.poll_cnt = 16'(POLL_CYCLES - 1);
    end else begin
      next_st.poll_cnt = st.poll_cnt - 16'h0001;
    end
    case (st.scan)
      mfc_pkg::SCAN_IDLE: begin
        next_st.rx_ok = 1'b1;
        if (rx_last_desc_done_i && st.feat[mfc_pkg::BIT_LAPP]) begin
          next_st.scan = mfc_pkg::SCAN_RUN; // R6
          next_st.rx_ok = 1'b0; // R5
          next_st.adv = 1'b1;
          next_st.fetch = 1'b1;
        end
      end
      mfc_pkg::SCAN_RUN: begin
        if (desc_valid_i) begin
          if (desc_start_i && desc_own_i) begin
            next_st.scan = mfc_pkg::SCAN_WAIT; // R9
          end else if (desc_start_i) begin
            next_st.scan = mfc_pkg::SCAN_POLL; // R8
          end else begin
            next_st.clr_own = desc_own_i; // R6
            next_st.adv = 1'b1; // R7
            next_st.fetch = 1'b1;
          end
        end
      end
      mfc_pkg::SCAN_POLL: begin
        if (st.poll_cnt == 16'h0000) begin
          next_st.fetch = 1'b1; // R8
        end
        if (desc_valid_i && desc_start_i && desc_own_i) begin
          next_st.scan = mfc_pkg::SCAN_WAIT;
        end
      end
      mfc_pkg::SCAN_WAIT: begin
        if (rx_frame_arrive_i) begin
          next_st.scan = mfc_pkg::SCAN_IDLE; // R9
          next_st.rx_ok = 1'b1; // R5
        end
      end
      default: next_st.scan = mfc_pkg::SCAN_IDLE;
    endcase
    // ------------------------------------------------------------
    // bus mastership hold
    // ------------------------------------------------------------
    if (bus_req_i) begin
      if (!st.feat[mfc_pkg::BIT_TIMER] && st.hold && bus_req_type_change_i) begin
        next_st.hold = 1'b0; // R17
      end else begin
        next_st.hold = 1'b1;
        next_st.hold_cnt = 16'(HOLD_CYCLES); // R16
      end
    end else if (st.feat[mfc_pkg::BIT_TIMER] && st.hold) begin
      if (st.hold_cnt <= 16'h0001) begin
        next_st.hold = 1'b0; // R15
      end else begin
        next_st.hold_cnt = st.hold_cnt - 16'h0001; // R16
      end
    end else begin
      next_st.hold = 1'b0; // R17
    end
    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    next_st.rdata = 32'h0000_0000;
    if (rd) begin
      case (adr_i)
        mfc_pkg::ADDR_FEATURE: next_st.rdata = {16'h0000, st.feat};
        mfc_pkg::ADDR_STATUS: next_st.rdata = {25'h000_0000, st.test_armed, st.scan == mfc_pkg::SCAN_WAIT,
          st.scan == mfc_pkg::SCAN_POLL, st.hold, st.receive_interrupt_flag, st.summary, st.transmitter_on_flag};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (rst_i || reset_reg_read_i) begin
      next_st.feat[mfc_pkg::BIT_TRANSMIT_UNDERFLOW_ERROR_DIS] = 1'b0; // R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_reg_read_i) begin
      st <= '0;
      st.feat <= mfc_pkg::FEATURE_RESET; // R23
      st.test_armed <= 1'b1; // R13
      st.poll_cnt <= 16'h0000;
      st.hold_cnt <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign transmitter_on_flag_o = st.transmitter_on_flag;
  assign tx_ring_skip_o = st.skip;
  assign tx_poll_o = st.poll;
  assign two_part_deferral_disable_o = st.feat[mfc_pkg::BIT_DEFER_DIS]; // R11
  assign modified_backoff_enable_o = st.feat[mfc_pkg::BIT_MODIFIED_BACKOFF_ENABLE]; // R12
  assign auto_pad_transmit_o = st.feat[mfc_pkg::BIT_APAD]; // R19
  assign auto_strip_receive_o = st.feat[mfc_pkg::BIT_ASTRP]; // R20
  assign burst_counter_disable_o = st.feat[mfc_pkg::BIT_BURST_DIS]; // R14
  assign test_mode_enable_o = st.feat[mfc_pkg::BIT_TEST];
  assign desc_fetch_o = st.fetch;
  assign desc_clear_own_o = st.clr_own;
  assign desc_advance_o = st.adv;
  assign rx_start_allowed_o = st.rx_ok;
  assign receive_interrupt_flag_o = st.receive_interrupt_flag;
  assign bus_hold_o = st.hold;
  assign interrupt_summary_flag_o = st.summary;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || reset_reg_read_i);

  // ------------------------------------------------------------
  // helper: idle cycles while the timer holds the bus
  // ------------------------------------------------------------
  logic [16:0] idle_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || reset_reg_read_i || !(st.feat[13] && bus_hold_o && !bus_req_i)) begin
      idle_cnt <= 17'h0_0000;
    end else if (idle_cnt != 17'h1_ffff) begin
      idle_cnt <= idle_cnt + 17'h0_0001;
    end
  end

  AST_TRANSMIT_UNDERFLOW_ERROR_OFF: assert property (transmit_underflow_error_i && st.transmitter_on_flag && !st.feat[6] && !missed_frame_counter_ovf_i
    |=> !transmitter_on_flag_o) else $error("transmitter stayed on after underflow"); // R1
  AST_TRANSMIT_UNDERFLOW_ERROR_SKIP: assert property (transmit_underflow_error_i && st.transmitter_on_flag && st.feat[6]
    |=> tx_ring_skip_o) else $error("no ring skip on recovered underflow"); // R2
  AST_LAPP_RECEIVE_INTERRUPT_FLAG: assert property (rx_first_desc_done_i && st.feat[5] |=> receive_interrupt_flag_o)
    else $error("no look-ahead receive interrupt"); // R4
  AST_SKIP_OWN: assert property (st.scan == mfc_pkg::SCAN_RUN && desc_valid_i && !desc_start_i && desc_own_i
    |=> desc_clear_own_o && desc_advance_o) else $error("owned skipped entry not cleared"); // R6
  AST_HOST_ENTRY: assert property (st.scan == mfc_pkg::SCAN_RUN && desc_valid_i && !desc_start_i && !desc_own_i
    |=> !desc_clear_own_o && desc_advance_o) else $error("host entry altered"); // R7
  AST_STP_POLL: assert property (st.scan == mfc_pkg::SCAN_RUN && desc_valid_i && desc_start_i && !desc_own_i
    |=> st.scan == mfc_pkg::SCAN_POLL ##1 !desc_advance_o) else $error("did not stop on host start entry"); // R8
  AST_STP_WAIT: assert property (st.scan == mfc_pkg::SCAN_WAIT && !rx_frame_arrive_i
    |=> st.scan == mfc_pkg::SCAN_WAIT && !rx_start_allowed_o) else $error("left wait early"); // R9
  AST_MISSED_FRAME_OVERFLOW_FLAG_SET: assert property (missed_frame_counter_ovf_i |=> st.feat[9]) else $error("overflow flag lost"); // R21
  AST_MASK: assert property (st.feat[8] |-> !interrupt_summary_flag_o)
    else $error("masked overflow reached summary"); // R22
  AST_TIMER_REL: assert property (idle_cnt <= 17'(HOLD_CYCLES) + 17'h0_0002) // R16
    else $error("bus held past timer");
  AST_TEST_LOCK: assert property (!st.test_armed && !test_mode_enable_o |=> !test_mode_enable_o) // R13
    else $error("test mode raised after lock");
  AST_STOP_KEEP: assert property (stop |=> $stable({st.feat[15:10], st.feat[8:3]})) // R10
    else $error("stop altered feature bits");
  AST_POLL_DEMAND: assert property (st.transmitter_on_flag && st.feat[12] && wr && adr_i == mfc_pkg::ADDR_CMD && sel_i[0]
    && dat_i[mfc_pkg::CMD_TX_DEMAND] |=> tx_poll_o) // R18
    else $error("demand did not poll");
  AST_RX_HOLD: assert property (st.scan == mfc_pkg::SCAN_RUN |-> !rx_start_allowed_o) // R5
    else $error("packet start allowed during scan");
  AST_NO_POLL_OFF: assert property (!st.transmitter_on_flag |=> !tx_poll_o) else $error("poll while transmitter off"); // R18

  COV_SCAN_WAIT: cover property (st.scan == mfc_pkg::SCAN_RUN ##[1:20] st.scan == mfc_pkg::SCAN_WAIT);
  COV_SCAN_POLL: cover property (st.scan == mfc_pkg::SCAN_POLL ##1 desc_fetch_o);
  COV_TRANSMIT_UNDERFLOW_ERROR: cover property (transmit_underflow_error_i && st.transmitter_on_flag);
  COV_MISSED_FRAME_OVERFLOW_FLAG_CLR: cover property (st.feat[9] ##1 !st.feat[9]);
  COV_TEST_ON: cover property (test_mode_enable_o);

endmodule : mfc_feature_ctrl

//--- tb/mfc_host_model.sv
module mfc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic desc_fetch_i,
  input wire logic desc_advance_i,
  input wire logic [7:0] ring_i,
  output logic desc_valid_o,
  output logic desc_own_o,
  output logic desc_start_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] idx = 2'h0;
  initial begin
    desc_valid_o = 1'h0;
    desc_own_o = 1'h0;
    desc_start_o = 1'h0;
  end
  // ring entry k is {start, own} at bits 2k+1:2k
  always @(posedge clk_i) begin
    desc_valid_o <= desc_fetch_i;
    if (desc_fetch_i) begin
      desc_own_o <= ring_i[2*idx];
      desc_start_o <= ring_i[2*idx+1];
    end else begin
      // unfetched cycles: lines toggle each cycle, so no stale value
      desc_own_o <= ~desc_own_o;
      desc_start_o <= ~desc_start_o;
    end
    if (rst_i) begin
      idx <= 2'h0;
    end else if (desc_advance_i) begin
      idx <= idx + 2'h1;
    end
  end
endmodule : mfc_host_model

//--- tb/mfc_feature_ctrl_bench.sv
module mfc_feature_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [3:0] AF = mfc_pkg::ADDR_FEATURE;
  localparam logic [3:0] AS = mfc_pkg::ADDR_STATUS;
  localparam logic [3:0] AC = mfc_pkg::ADDR_CMD;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, q;
  logic [5:0] pls = 6'h00;
  logic [7:0] ring = 8'h00;
  logic tx_frame_start_found_i = 1'h0;
  logic rx_frame_arrive_i = 1'h0;
  logic bus_req_type_change_i = 1'h0;
  wire logic reset_reg_read_i = pls[0];
  wire logic transmit_underflow_error_i = pls[1];
  wire logic rx_first_desc_done_i = pls[2];
  wire logic rx_last_desc_done_i = pls[3];
  wire logic missed_frame_counter_ovf_i = pls[4];
  wire logic bus_req_i = pls[5];
  logic ack_o, transmitter_on_flag_o, tx_ring_skip_o, tx_poll_o, two_part_deferral_disable_o;
  logic modified_backoff_enable_o, auto_pad_transmit_o, auto_strip_receive_o, burst_counter_disable_o;
  logic test_mode_enable_o, desc_fetch_o, desc_clear_own_o, desc_advance_o, rx_start_allowed_o;
  logic receive_interrupt_flag_o, bus_hold_o, interrupt_summary_flag_o, desc_valid_i, desc_own_i, desc_start_i;
  int n_fail = 0;
  int tests_run = 0;
  int n_receive_interrupt_flag = 0;
  int n_skip = 0;
  int n_poll = 0;
  int n_clr = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (receive_interrupt_flag_o === 1'h1) n_receive_interrupt_flag++;
    if (tx_ring_skip_o === 1'h1) n_skip++;
    if (tx_poll_o === 1'h1) n_poll++;
    if (desc_clear_own_o === 1'h1) n_clr++;
  end
  mfc_feature_ctrl #(.HOLD_CYCLES(4), .POLL_CYCLES(4)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .reset_reg_read_i, .transmit_underflow_error_i,
    .tx_frame_start_found_i, .transmitter_on_flag_o, .tx_ring_skip_o, .tx_poll_o, .two_part_deferral_disable_o,
    .modified_backoff_enable_o, .auto_pad_transmit_o, .auto_strip_receive_o, .burst_counter_disable_o,
    .test_mode_enable_o, .rx_first_desc_done_i, .rx_last_desc_done_i, .desc_valid_i, .desc_own_i,
    .desc_start_i, .rx_frame_arrive_i, .desc_fetch_o, .desc_clear_own_o, .desc_advance_o, .rx_start_allowed_o,
    .receive_interrupt_flag_o, .bus_req_i, .bus_req_type_change_i, .bus_hold_o, .missed_frame_counter_ovf_i,
    .interrupt_summary_flag_o);
  mfc_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .desc_fetch_i(desc_fetch_o), .desc_advance_i(desc_advance_o),
    .ring_i(ring), .desc_valid_o(desc_valid_i), .desc_own_o(desc_own_i), .desc_start_o(desc_start_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (n >= 20) n_fail++;
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask : wb
  task automatic pulse(input int b);
    pls[b] <= 1'h1;
    @(posedge clk_i);
    pls[b] <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask : pulse
  task automatic do_reset;
    rst_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
  endtask : do_reset
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_test;
    do_reset();
    wb(0, AF, 0);
    chk("feature_reset", 32'h0000_0100, q);
    chk("option_outputs", 32'h0, {two_part_deferral_disable_o, modified_backoff_enable_o, auto_pad_transmit_o,
      auto_strip_receive_o, burst_counter_disable_o, test_mode_enable_o});
    wb(0, 4'h2, 0);
    chk("unmapped", 32'h0, q);
    wb(1, AF, 32'h0000_8100);
    chk("test_on", 32'h1, test_mode_enable_o);
    wb(1, AF, 32'h0000_0100);
    wb(1, AF, 32'h0000_8100);
    chk("test_locked", 32'h0, test_mode_enable_o);
  endtask : t_reset_test
  task automatic t_feature;
    do_reset();
    wb(1, AF, 32'h0000_7d7f);
    wb(0, AF, 0);
    chk("feature_rw", 32'h0000_7d78, q);
    chk("option_outputs", 32'h1f, {burst_counter_disable_o, auto_pad_transmit_o, auto_strip_receive_o,
      two_part_deferral_disable_o, modified_backoff_enable_o});
    wb(1, AC, 32'h1);
    wb(0, AF, 0);
    chk("feature_after_stop", 32'h0000_7d78, q);
  endtask : t_feature
  task automatic t_underflow;
    do_reset();
    wb(1, AF, 0);
    wb(1, AC, 32'h8);
    chk("transmitter_on_flag_start", 32'h1, transmitter_on_flag_o);
    pulse(1);
    chk("transmitter_on_flag_after_transmit_underflow_error", 32'h0, transmitter_on_flag_o);
    wb(1, AF, 32'h40);
    wb(1, AC, 32'h8);
    n_skip = 0;
    pulse(1);
    chk("skip_count", 32'h1, n_skip);
    chk("transmitter_on_flag_recover", 32'h1, transmitter_on_flag_o);
    pulse(0);
    wb(0, AF, 0);
    chk("feature_reg_reset", 32'h0000_0100, q);
  endtask : t_underflow
  task automatic t_poll;
    do_reset();
    wb(1, AC, 32'h8);
    wb(1, AF, 32'h0000_1100);
    n_poll = 0;
    repeat (30) @(posedge clk_i);
    chk("no_auto_poll", 32'h0, n_poll);
    wb(1, AC, 32'h4);
    chk("demand_poll", 32'h1, n_poll);
    wb(1, AC, 32'h1);
    n_poll = 0;
    wb(1, AC, 32'h4);
    chk("poll_when_off", 32'h0, n_poll);
  endtask : t_poll
  task automatic t_overflow;
    do_reset();
    wb(1, AF, 0);
    pulse(4);
    wb(0, AF, 0);
    chk("missed_frame_overflow_flag_set", 32'h200, q & 32'h0000_0200);
    chk("summary_on", 32'h1, interrupt_summary_flag_o);
    wb(1, AF, 0);
    wb(0, AF, 0);
    chk("missed_frame_overflow_flag_w0", 32'h200, q & 32'h0000_0200);
    wb(1, AF, 32'h200);
    wb(0, AF, 0);
    chk("missed_frame_overflow_flag_w1c", 32'h0, q & 32'h0000_0200);
    pulse(4);
    wb(1, AF, 32'h100);
    chk("summary_masked", 32'h0, interrupt_summary_flag_o);
    wb(1, AC, 32'h1);
    wb(0, AF, 0);
    chk("missed_frame_overflow_flag_stop", 32'h0, q & 32'h0000_0200);
  endtask : t_overflow
  task automatic t_lookahead;
    do_reset();
    ring = 8'h31;
    wb(1, AF, 32'h120);
    n_receive_interrupt_flag = 0;
    n_clr = 0;
    pulse(2);
    chk("receive_interrupt_flag_first", 32'h1, n_receive_interrupt_flag);
    pulse(3);
    repeat (40) @(posedge clk_i);
    chk("receive_interrupt_flag_last", 32'h2, n_receive_interrupt_flag);
    chk("own_cleared", 32'h1, n_clr);
    wb(0, AS, 0);
    chk("scan_wait", 32'h1, (q >> mfc_pkg::ST_SCAN_WAIT) & 32'h1);
    do_reset();
    ring = 8'h02;
    wb(1, AF, 32'h120);
    n_clr = 0;
    pulse(3);
    repeat (40) @(posedge clk_i);
    wb(0, AS, 0);
    chk("scan_poll", 32'h1, (q >> mfc_pkg::ST_SCAN_POLL) & 32'h1);
    chk("poll_no_clear", 32'h0, n_clr);
  endtask : t_lookahead
  task automatic t_bus;
    do_reset();
    wb(1, AF, 32'h2100);
    pls[5] <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("hold_busy", 32'h1, bus_hold_o);
    pls[5] <= 1'h0;
    repeat (10) @(posedge clk_i);
    chk("hold_released", 32'h0, bus_hold_o);
  endtask : t_bus
  // ----------------------------------------
  // main and watchdog
  // ----------------------------------------
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    t_reset_test();
    t_feature();
    t_underflow();
    t_poll();
    t_overflow();
    t_lookahead();
    t_bus();
    final_report();
  end
endmodule : mfc_feature_ctrl_bench
